// ### sar_pkg.sv
// Purpose: Shared constants for the storage address register and class decoder
// Assumes: Fifteen-stage address, five class-select stages at the top
// Notes: Addresses are octal in the machine's notation, hex here
package sar_pkg;
    // Register geometry
    localparam int ADDR_W = 15;
    localparam int CLASS_LSB = 10;
    localparam int CLASS_W = 5;
    localparam int CORE_W = 10;
    localparam int ANGLE_W = 12;
    localparam int GROUP_LSB = 12;
    localparam int GROUP_W = 3;
    localparam int DRUM_BIT = 14;
    // Fixed address values
    localparam logic [14:0] ADDR_ZERO = 15'h0000;
    localparam logic [14:0] ONE_ADDR = 15'h0001;
    localparam logic [14:0] DRUM_START_ADDR = 15'h4001;
    localparam logic [14:0] DRUM_BASE = 15'h4000;
    localparam logic [14:0] CORE_LAST = 15'h03ff;
    localparam logic [14:0] DRUM_LAST = 15'h7fff;
    // Class select patterns on the top stages
    localparam logic [4:0] CORE_TOP = 5'h00;
    localparam logic [2:0] QUOT_TOP = 3'h1;
    localparam logic [2:0] ACCUM_TOP = 3'h2;
endpackage

// ### class_if.sv
// Purpose: Carries storage class enables from decoder to register
// Assumes: Enables are levels, valid while the address is stable
// Notes: Unassigned is the fault-detector view of no class at all
`timescale 1ns/10ps
interface class_if;
    logic core_en;     // Core storage selected
    logic quot_en;     // One-word quotient register selected
    logic accum_en;    // Accumulator selected
    logic drum_en;     // Drum storage selected
    logic not_core_en; // Any class stage set
    logic unassigned;  // No class owns this address
    modport decoder (output core_en, quot_en, accum_en, drum_en, not_core_en, unassigned);
    modport user (input core_en, quot_en, accum_en, drum_en, not_core_en, unassigned);
endinterface

// ### address_stage.sv
// Purpose: One settable and clearable address stage
// Assumes: Clear, preset and set are one-cycle pulses on core_clk
// Notes: Clear acts before set, so a set in the same cycle survives
`timescale 1ns/10ps
module address_stage (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Stage controls
    input wire logic clear,
    input wire logic preset,
    input wire logic set,
    // Stage value
    output logic q
);
    logic next_q; // Value at next edge

    // Clear first, then OR in preset and set
    always_comb begin
        next_q = (q & ~clear) | preset | set;
    end

    // Stage flip-flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end
endmodule

// ### storage_class_decoder.sv
// Purpose: Combinational storage class decoder on the top five stages
// Assumes: Low ten stages never reach this module
// Notes: Exactly one of the four class enables (not not_core_en) or unassigned is high at a time
`timescale 1ns/10ps
module storage_class_decoder
    import sar_pkg::*;
(
    // Class-select stages
    input wire logic [4:0] top_bits,
    // Class enables
    class_if.decoder cls
);
    logic [2:0] top3; // Group digit

    // Pure gating, no state; low stages are not even ported in
    always_comb begin
        top3 = top_bits[CLASS_W-1:CLASS_W-GROUP_W];
        cls.core_en = (top_bits == CORE_TOP);
        cls.quot_en = (top3 == QUOT_TOP);
        cls.accum_en = (top3 == ACCUM_TOP);
        cls.drum_en = top_bits[CLASS_W-1];
        cls.not_core_en = |top_bits;
        cls.unassigned = ~(cls.core_en | cls.quot_en | cls.accum_en | cls.drum_en);
    end
endmodule

// ### storage_address_reg.sv
// Purpose: Storage address register with class decode and transfers
// Assumes: All strobes are one-cycle pulses from logic on core_clk
// Notes: Loads and sends move ones only, as in the original gate sets
`timescale 1ns/10ps

// Contract
// - Fifteen individually settable and clearable stages
// - Counter load sets stages on source ones
// - Load into nonzero register ORs contents
// - Send ones into low exchange stages
// - Send ones into program counter stages
// - Start-up, core position, clears to 00000
// - Start-up, drum position, gives 40001
// - Storage resume clears the register
// - Arithmetic access clear request clears register
// - Core class on top six 00/01
// - Quotient class on top three 1
// - Accumulator class on top three 2
// - Drum class on top three 4-7
// - Drum gets angle bits, all stages
// - Core gets only stages 0-9
// - Quotient and accumulator ignore low bits
// - Unassigned reference raises halting class fault
// - Decoder combinational, top five stages only
// - Stepping wraps within the core and drum ranges; quotient and accumulator keep the address
// - Fifth enable marks any high class stage
module storage_address_reg
    import sar_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Loads from the address counters
    input wire logic load_from_program_counter,
    input wire logic load_from_u_counter,
    input wire logic load_from_v_counter,
    input wire logic [14:0] program_counter_value,
    input wire logic [14:0] u_counter_value,
    input wire logic [14:0] v_counter_value,
    // Clears and start-up
    input wire logic startup_clear_strobe,
    input wire logic start_location_switch,
    input wire logic storage_resume,
    input wire logic arith_clear_request,
    // Sends to exchange and program counter
    input wire logic send_to_exchange,
    input wire logic send_to_program_counter,
    output logic [14:0] exchange_set,
    output logic [14:0] program_counter_set,
    // Reference and fault
    input wire logic reference_request,
    output logic class_fault,
    // Address outputs
    output logic [14:0] storage_address,
    output logic [9:0] core_address,
    output logic [14:0] drum_address,
    output logic [11:0] drum_angle,
    output logic [2:0] drum_group,
    output logic [14:0] step_address,
    // Class enables
    output logic core_storage_class,
    output logic quot_class,
    output logic accum_class,
    output logic drum_storage_class,
    output logic not_core_enable
);
    // Width is fixed by the addressing scheme
    if (ADDR_WIDTH != ADDR_W) begin : g_width_check
        $error("storage_address_reg supports only a 15-stage address");
    end

    class_if cls (); // Decoder to register enables

    logic switch_meta;        // Switch synchroniser, first stage
    logic switch_drum;        // Switch synchronised, high for drum
    logic next_switch_meta;   // Next first stage
    logic next_switch_drum;   // Next second stage
    logic address_clear_strobe; // Any clear this cycle
    logic [14:0] preset_bits; // Start-up preset pattern
    logic [14:0] load_bits;   // Ones arriving from counters
    logic [14:0] next_address; // Value after this edge
    logic [14:0] next_exchange_set; // Next exchange pulse bits
    logic [14:0] next_pc_set; // Next program counter pulse bits
    logic next_class_fault;   // Next fault state
    logic [14:0] next_step;   // Next in-class successor

    // Switch comes from a panel, so two flops before use
    always_comb begin
        next_switch_meta = start_location_switch;
        next_switch_drum = switch_meta;
    end

    // Synchroniser flops; the first is read only by the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            switch_meta <= 1'b0;
            switch_drum <= 1'b0;
        end else begin
            switch_meta <= next_switch_meta;
            switch_drum <= next_switch_drum;
        end
    end

    // Clear, preset and load terms for every stage
    always_comb begin
        address_clear_strobe = startup_clear_strobe | storage_resume | arith_clear_request;
        preset_bits = (startup_clear_strobe && switch_drum) ? DRUM_START_ADDR : ADDR_ZERO;
        load_bits = ({ADDR_W{load_from_program_counter}} & program_counter_value)
                  | ({ADDR_W{load_from_u_counter}} & u_counter_value)
                  | ({ADDR_W{load_from_v_counter}} & v_counter_value);
        next_address = (storage_address & ~{ADDR_W{address_clear_strobe}}) | preset_bits | load_bits;
    end

    for (genvar i = 0; i < ADDR_W; i++) begin : g_stage
        address_stage u_stage (
            .core_clk(core_clk),
            .rstn(rstn),
            .clear(address_clear_strobe),
            .preset(preset_bits[i]),
            .set(load_bits[i]),
            .q(storage_address[i])
        );
    end

    // decoder sees top five stages only
    storage_class_decoder u_decoder (
        .top_bits(storage_address[ADDR_W-1:CLASS_LSB]),
        .cls(cls)
    );

    // Enables straight from the decoder
    always_comb begin
        core_storage_class = cls.core_en;
        quot_class = cls.quot_en;
        accum_class = cls.accum_en;
        drum_storage_class = cls.drum_en;
        not_core_enable = cls.not_core_en;
    end

    // Location fields, wires from the stages
    always_comb begin
        core_address = storage_address[CORE_W-1:0];
        drum_address = storage_address;
        drum_angle = storage_address[ANGLE_W-1:0];
        drum_group = storage_address[GROUP_LSB+GROUP_W-1:GROUP_LSB];
    end

    // Transfer pulses and fault; step follows the new address
    always_comb begin
        next_exchange_set = send_to_exchange ? storage_address : ADDR_ZERO;
        next_pc_set = send_to_program_counter ? storage_address : ADDR_ZERO;
        next_class_fault = class_fault | (reference_request & cls.unassigned);
        if (next_address[ADDR_W-1:CLASS_LSB] == CORE_TOP) begin
            next_step = (next_address == CORE_LAST) ? ADDR_ZERO : next_address + ONE_ADDR;
        end else if (next_address[DRUM_BIT]) begin
            next_step = (next_address == DRUM_LAST) ? DRUM_BASE : next_address + ONE_ADDR;
        end else begin
            next_step = next_address;
        end
    end

    // Output registers; a fault holds until reset to keep the halt
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            exchange_set <= ADDR_ZERO;
            program_counter_set <= ADDR_ZERO;
            class_fault <= 1'b0;
            step_address <= ONE_ADDR;
        end else begin
            exchange_set <= next_exchange_set;
            program_counter_set <= next_pc_set;
            class_fault <= next_class_fault;
            step_address <= next_step;
        end
    end

    // Checks on the register, all in the core_clk domain
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic any_load; // Any counter load this cycle
    assign any_load = load_from_program_counter | load_from_u_counter | load_from_v_counter;

    property p_load_sets;
        load_from_program_counter |=> ((storage_address & $past(program_counter_value))
                                      == $past(program_counter_value));
    endproperty
    a_load_sets: assert property (p_load_sets) else $error("load lost a source one");

    property p_or_merge;
        (any_load && !address_clear_strobe) |=>
            storage_address == ($past(storage_address) | $past(load_bits));
    endproperty
    a_or_merge: assert property (p_or_merge) else $error("load did not OR into contents");

    property p_hold;
        (!any_load && !address_clear_strobe) |=> $stable(storage_address);
    endproperty
    a_hold: assert property (p_hold) else $error("address changed without a strobe");

    property p_exchange;
        send_to_exchange |=> exchange_set == $past(storage_address)
            ##1 (exchange_set == ADDR_ZERO || $past(send_to_exchange));
    endproperty
    a_exchange: assert property (p_exchange) else $error("exchange pulse wrong");

    property p_pc_send;
        !send_to_program_counter |=> program_counter_set == ADDR_ZERO;
    endproperty
    a_pc_send: assert property (p_pc_send) else $error("program counter set without strobe");

    property p_pc_value;
        send_to_program_counter |=> program_counter_set == $past(storage_address);
    endproperty
    a_pc_value: assert property (p_pc_value) else $error("program counter set bits wrong");

    property p_startup_core;
        (startup_clear_strobe && !switch_drum && !any_load) |=> storage_address == ADDR_ZERO;
    endproperty
    a_startup_core: assert property (p_startup_core) else $error("core start not 00000");

    property p_startup_drum;
        (startup_clear_strobe && switch_drum && !any_load) |=> storage_address == DRUM_START_ADDR;
    endproperty
    a_startup_drum: assert property (p_startup_drum) else $error("drum start not 40001");

    property p_resume_clear;
        (storage_resume && !startup_clear_strobe && !any_load) |=> storage_address == ADDR_ZERO;
    endproperty
    a_resume_clear: assert property (p_resume_clear) else $error("resume did not clear");

    property p_arith_clear;
        (arith_clear_request && !startup_clear_strobe && !any_load) |=> storage_address == ADDR_ZERO;
    endproperty
    a_arith_clear: assert property (p_arith_clear) else $error("arith clear ignored");

    property p_clear_then_load;
        (arith_clear_request && !startup_clear_strobe) |=> storage_address == $past(load_bits);
    endproperty
    a_clear_then_load: assert property (p_clear_then_load) else $error("clear and load misordered");

    property p_core_class;
        core_storage_class == (storage_address <= CORE_LAST);
    endproperty
    a_core_class: assert property (p_core_class) else $error("core class decode wrong");

    property p_single_class;
        $onehot({core_storage_class, quot_class, accum_class, drum_storage_class, cls.unassigned});
    endproperty
    a_single_class: assert property (p_single_class) else $error("class enables not exclusive");

    property p_not_core;
        not_core_enable == !core_storage_class;
    endproperty
    a_not_core: assert property (p_not_core) else $error("not-core enable wrong");

    property p_fault;
        (reference_request && !core_storage_class && !quot_class && !accum_class
         && !drum_storage_class) |=> class_fault [*3];
    endproperty
    a_fault: assert property (p_fault) else $error("class fault not raised and held");

    property p_no_fault;
        (!class_fault && !(reference_request && cls.unassigned)) |=> !class_fault;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("spurious class fault");

    property p_core_wrap;
        storage_address == CORE_LAST |-> step_address == ADDR_ZERO;
    endproperty
    a_core_wrap: assert property (p_core_wrap) else $error("core step did not wrap");

    property p_drum_wrap;
        storage_address == DRUM_LAST |-> step_address == DRUM_BASE;
    endproperty
    a_drum_wrap: assert property (p_drum_wrap) else $error("drum step did not wrap");

    property p_fields;
        core_address == storage_address[9:0] && drum_angle == storage_address[11:0];
    endproperty
    a_fields: assert property (p_fields) else $error("location fields wrong");

    // Single-word and drum decodes, checked against the stage pattern
    property p_quot_class;
        quot_class == (storage_address[ADDR_W-1:GROUP_LSB] == QUOT_TOP);
    endproperty
    a_quot_class: assert property (p_quot_class) else $error("quotient class decode wrong");

    property p_accum_class;
        accum_class == (storage_address[ADDR_W-1:GROUP_LSB] == ACCUM_TOP);
    endproperty
    a_accum_class: assert property (p_accum_class) else $error("accumulator class decode wrong");

    property p_drum_class;
        drum_storage_class == storage_address[DRUM_BIT];
    endproperty
    a_drum_class: assert property (p_drum_class) else $error("drum class decode wrong");

    property p_drum_fields;
        drum_group == storage_address[ADDR_W-1:GROUP_LSB] && drum_address == storage_address;
    endproperty
    a_drum_fields: assert property (p_drum_fields) else $error("drum fields wrong");

    // Exchange bits stay quiet between sends, or the far side gets stray ones
    property p_exchange_idle;
        !send_to_exchange |=> exchange_set == ADDR_ZERO;
    endproperty
    a_exchange_idle: assert property (p_exchange_idle) else $error("exchange set without strobe");

    // Inside a looping class the successor is one up, end points excluded
    property p_step_next;
        ((core_storage_class && storage_address != CORE_LAST)
         || (drum_storage_class && storage_address != DRUM_LAST))
            |-> step_address == storage_address + ONE_ADDR;
    endproperty
    a_step_next: assert property (p_step_next) else $error("in-class step wrong");

    // Single-word classes keep the address as their own successor
    property p_single_word;
        (quot_class || accum_class) |-> step_address == storage_address;
    endproperty
    a_single_word: assert property (p_single_word) else $error("single-word step moved");

    // Main scenarios worth seeing
    c_drum_start: cover property (startup_clear_strobe && switch_drum ##1
                                  storage_address == DRUM_START_ADDR);
    c_or_merge: cover property (any_load && storage_address != ADDR_ZERO && !address_clear_strobe);
    c_fault: cover property (reference_request && cls.unassigned ##1 class_fault);
    c_wrap: cover property (storage_address == CORE_LAST);
endmodule

// ### ctrl_model.sv
// Purpose: Control-side model issuing strobes to the storage address register
// Assumes: Strobes launched at the falling edge of core_clk, one cycle wide
// Notes: Counter values not being loaded show the inverse of the value being loaded
`timescale 1ns/10ps
module ctrl_model (
    // Clock
    input wire logic core_clk,
    // Load strobes and counter values
    output logic load_from_program_counter,
    output logic load_from_u_counter,
    output logic load_from_v_counter,
    output logic [14:0] program_counter_value,
    output logic [14:0] u_counter_value,
    output logic [14:0] v_counter_value,
    // Clears and start-up
    output logic startup_clear_strobe,
    output logic start_location_switch,
    output logic storage_resume,
    output logic arith_clear_request,
    // Sends and reference
    output logic send_to_exchange,
    output logic send_to_program_counter,
    output logic reference_request
);
    // Idle at time zero
    initial begin
        {reference_request, send_to_program_counter, send_to_exchange} = 3'h0;
        {load_from_v_counter, load_from_u_counter, load_from_program_counter} = 3'h0;
        {startup_clear_strobe, storage_resume, arith_clear_request} = 3'h0;
        start_location_switch = 1'b0;
        program_counter_value = 15'h0000;
        u_counter_value = 15'h0000;
        v_counter_value = 15'h0000;
    end

    // clear before load: callers pair a clear with each fresh load
    // One-cycle strobe set, unused sources carry a changing pattern
    task automatic fire(input logic [8:0] s, input logic [14:0] val);
        @(negedge core_clk);
        {reference_request, send_to_program_counter, send_to_exchange} = s[8:6];
        {load_from_v_counter, load_from_u_counter, load_from_program_counter} = s[5:3];
        {startup_clear_strobe, storage_resume, arith_clear_request} = s[2:0];
        program_counter_value = s[3] ? val : ~val;
        u_counter_value = s[4] ? val : ~val;
        v_counter_value = s[5] ? val : ~val;
        @(negedge core_clk);
        // Release; values invert, so the loaded source no longer holds the loaded data
        {reference_request, send_to_program_counter, send_to_exchange} = 3'h0;
        {load_from_v_counter, load_from_u_counter, load_from_program_counter} = 3'h0;
        {startup_clear_strobe, storage_resume, arith_clear_request} = 3'h0;
        program_counter_value = ~program_counter_value;
        u_counter_value = ~u_counter_value;
        v_counter_value = ~v_counter_value;
    endtask

    // Switch is a level; settle time is left to the caller
    task automatic set_switch(input logic drum);
        @(negedge core_clk);
        start_location_switch = drum;
    endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the storage address register
// Assumes: Strobes come from ctrl_model, reset driven here
// Notes: Class fault is sticky, so fault cases sit at the end
`timescale 1ns/10ps
module tb_top;
    import sar_pkg::*;
    // Strobe codes for ctrl_model.fire
    localparam logic [8:0] CLR = 9'h001, RES = 9'h002, STU = 9'h004, LPC = 9'h008;
    localparam logic [8:0] LU = 9'h010, LV = 9'h020, SX = 9'h040, SPC = 9'h080, REF = 9'h100;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic load_from_program_counter, load_from_u_counter, load_from_v_counter;
    logic [14:0] program_counter_value, u_counter_value, v_counter_value;
    logic startup_clear_strobe, start_location_switch, storage_resume, arith_clear_request;
    logic send_to_exchange, send_to_program_counter, reference_request, class_fault;
    logic [14:0] exchange_set, program_counter_set, storage_address, drum_address, step_address;
    logic [9:0] core_address;
    logic [11:0] drum_angle;
    logic [2:0] drum_group;
    logic core_storage_class, quot_class, accum_class, drum_storage_class, not_core_enable;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [14:0] addrs [11] = '{15'h0000, 15'h03ff, 15'h1000, 15'h1fff, 15'h2abc, 15'h4000,
                                15'h6123, 15'h7fff, 15'h0400, 15'h0fff, 15'h3000};
    logic [14:0] a, st;
    logic [4:0] cls;

    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    ctrl_model i_ctrl_model (.core_clk, .load_from_program_counter, .load_from_u_counter,
        .load_from_v_counter, .program_counter_value, .u_counter_value, .v_counter_value,
        .startup_clear_strobe, .start_location_switch, .storage_resume, .arith_clear_request,
        .send_to_exchange, .send_to_program_counter, .reference_request);

    storage_address_reg i_storage_address_reg (.core_clk, .rstn, .load_from_program_counter,
        .load_from_u_counter, .load_from_v_counter, .program_counter_value, .u_counter_value,
        .v_counter_value, .startup_clear_strobe, .start_location_switch, .storage_resume,
        .arith_clear_request, .send_to_exchange, .send_to_program_counter, .exchange_set,
        .program_counter_set, .reference_request, .class_fault, .storage_address, .core_address,
        .drum_address, .drum_angle, .drum_group, .step_address, .core_storage_class, .quot_class,
        .accum_class, .drum_storage_class, .not_core_enable);

    // Single compare point; four-state safe
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset held five cycles, released at a falling edge
    task automatic do_reset();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
    endtask

    // Hang guard, well beyond the expected run of under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        do_reset();
        // Reset state: core class, zero address
        check(storage_address, 15'h0000);
        check({10'h0, core_storage_class, quot_class, accum_class, drum_storage_class,
               not_core_enable}, 15'h0010);
        $display("test reset done");
        // clear with load same cycle (u, program counter), then OR merge (v, program counter)
        i_ctrl_model.fire(CLR | LU, 15'h4123);
        check(storage_address, 15'h4123);
        i_ctrl_model.fire(LV, 15'h0005);
        check(storage_address, 15'h4127);
        i_ctrl_model.fire(LPC, 15'h2008);
        check(storage_address, 15'h612f);
        i_ctrl_model.fire(RES | LPC, 15'h0102);
        check(storage_address, 15'h0102);
        $display("test loads done");
        // Sends carry ones for one cycle; same-cycle clear sends old value
        i_ctrl_model.fire(CLR | LV, 15'h5a5a);
        i_ctrl_model.fire(SX | RES, 15'h0000);
        check(exchange_set, 15'h5a5a);
        check(program_counter_set, 15'h0000);
        check(storage_address, 15'h0000);
        @(negedge core_clk);
        check(exchange_set, 15'h0000);
        i_ctrl_model.fire(CLR | LU, 15'h2525);
        i_ctrl_model.fire(SPC | CLR, 15'h0000);
        check(program_counter_set, 15'h2525);
        check(exchange_set, 15'h0000);
        check(storage_address, 15'h0000);
        @(negedge core_clk);
        check(program_counter_set, 15'h0000);
        $display("test sends done");
        // Start-up with each switch position, after a nonzero load
        i_ctrl_model.set_switch(1'b1);
        i_ctrl_model.fire(CLR | LU, 15'h2222);
        repeat (3) @(negedge core_clk);
        i_ctrl_model.fire(STU, 15'h0000);
        check(storage_address, 15'h4001);
        check({14'h0, drum_storage_class}, 15'h0001);
        i_ctrl_model.set_switch(1'b0);
        i_ctrl_model.fire(LU, 15'h7776);
        repeat (3) @(negedge core_clk);
        i_ctrl_model.fire(STU, 15'h0000);
        check(storage_address, 15'h0000);
        $display("test startup done");
        // Class table, fields and in-class stepping
        foreach (addrs[i]) begin
            a = addrs[i];
            i_ctrl_model.fire(CLR | LU, a);
            cls = {a[14:10] == 5'h00, a[14:12] == 3'h1, a[14:12] == 3'h2, a[14], |a[14:10]};
            st = cls[4] ? ((a == 15'h03ff) ? 15'h0000 : a + 15'h0001) :
                 cls[1] ? ((a == 15'h7fff) ? 15'h4000 : a + 15'h0001) : a;
            check({10'h0, core_storage_class, quot_class, accum_class, drum_storage_class,
                   not_core_enable}, {10'h0, cls});
            check({5'h0, core_address}, {5'h0, a[9:0]});
            check({3'h0, drum_angle}, {3'h0, a[11:0]});
            check({drum_group, 12'h000}, {a[14:12], 12'h000});
            check(drum_address, a);
            check(step_address, st);
            if (i < 8) begin
                // Assigned references leave the fault low
                i_ctrl_model.fire(REF, 15'h0000);
                check({14'h0, class_fault}, 15'h0000);
            end
        end
        $display("test classes done");
        // Unassigned reference in each range, fault sticky until reset
        i_ctrl_model.fire(CLR | LU, 15'h0400);
        i_ctrl_model.fire(REF, 15'h0000);
        check({14'h0, class_fault}, 15'h0001);
        i_ctrl_model.fire(CLR, 15'h0000);
        check({14'h0, class_fault}, 15'h0001);
        do_reset();
        check({14'h0, class_fault}, 15'h0000);
        i_ctrl_model.fire(LV, 15'h3fff);
        i_ctrl_model.fire(REF, 15'h0000);
        check({14'h0, class_fault}, 15'h0001);
        $display("test faults done");
        tally_and_finish();
    end
endmodule
